// File: clock_switch_pkg.sv
// Constants and types shared by the system clock switch and fail-safe monitor
// Functional notes
// - Select field 00 runs the system from the configured oscillator mode.
// - Select field 01 runs CPU and peripherals from the secondary crystal.
// - Select field 1x runs from the internal block at the chosen frequency.
// - Every reset clears the clock select field to zero.
// - Automatic switches leave the select field alone; start-up status shows source.
// - Start-up status is set on the configured external source, clear on internal.
// - Crystal modes count 1024 oscillator cycles before that clock is used.
// - Two-speed start-up is off unless a crystal mode is configured.
// - Two-speed needs switchover bit 1, select field 00 and crystal mode.
// - Two-speed starts after power-up or wake, running on the internal clock.
// - After the count, set status on internal fall, hold low, switch on crystal fall.
// - Sleep aborts the start-up count and leaves start-up status clear.
// - Switches to secondary or from sleep or power-up wait the 1024 count.
// - The monitor runs only when enabled and covers all external sources.
// - Failure detection runs only once the start-up count has expired.
// - The sample clock is the low-frequency internal oscillator divided by 64.
// - Latch set by external fall, cleared by sample rise; empty half-cycle fails.
// - Failure moves to the internal clock, sets the fail flag, requests interrupt.
// - After failure the clock stays internal until firmware restarts the external.
// - Reset, sleep or a select change clear the failure; change restarts count.
// - The fail flag cannot be cleared while the failure is still present.
// - With the secondary oscillator disabled its ready bit reads as 1.
package clock_switch_pkg;

   // Register indices on the two-bit register port
   localparam logic [1:0] CTRL_OFFSET = 2'h0;
   localparam logic [1:0] STAT_OFFSET = 2'h1;
   localparam logic [1:0] FLAG_OFFSET = 2'h2;
   localparam logic [1:0] IEN_OFFSET = 2'h3;

   // Field positions
   localparam int SELECT_LSB = 0;
   localparam int FREQ_LSB = 3;
   localparam int STARTUP_STATUS_POS = 5;
   localparam int SEC_READY_POS = 7;
   localparam int FAIL_FLAG_POS = 7;
   localparam int FAIL_IEN_POS = 7;

   // Reset values
   localparam logic [1:0] SELECT_RESET = 2'h0;
   localparam logic [3:0] FREQ_RESET = 4'h7;

   // Configuration oscillator field codes
   localparam logic [2:0] CFG_LOW_POWER_XTAL = 3'h0;
   localparam logic [2:0] CFG_STANDARD_XTAL = 3'h1;
   localparam logic [2:0] CFG_HIGH_SPEED_XTAL = 3'h2;
   localparam logic [2:0] CFG_EXT_RC = 3'h3;
   localparam logic [2:0] CFG_INTERNAL = 3'h4;

   // Timing counts
   localparam int STARTUP_COUNT = 1024;
   localparam int STARTUP_CNT_W = 11;
   localparam int SAMPLE_DIVIDE = 64;
   localparam int SAMPLE_DIV_W = 6;

   typedef enum logic [1:0] {SRC_NONE, SRC_INT, SRC_PRI, SRC_SEC} clk_src_t;
   typedef enum logic [1:0] {SW_RUN, SW_HOLD, SW_WAIT_NEW} sw_state_t;

endpackage : clock_switch_pkg

// File: system_clock_switch_failsafe.sv
// System clock source selection, start-up counter, two-speed start-up and fail-safe monitor
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module system_clock_switch_failsafe
   import clock_switch_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_COUNT
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] config_oscillator_field,
   input wire logic switchover_config_bit,
   input wire logic monitor_enable_config_bit,
   input wire logic power_up_done,
   input wire logic sleep_mode,
   input wire logic primary_osc_in,
   input wire logic secondary_osc_in,
   input wire logic internal_osc_in,
   input wire logic low_freq_osc_in,
   input wire logic secondary_enable_bit,
   input wire logic secondary_osc_ready_in,
   output logic system_clk_out,
   output logic [3:0] internal_freq_select,
   output logic [1:0] active_source,
   output logic osc_fail_irq
);

   localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_CNT_W'(STARTUP_CYCLES - 1);
   localparam logic [SAMPLE_DIV_W-1:0] SAMPLE_RISE_AT = SAMPLE_DIV_W'(SAMPLE_DIVIDE / 2 - 1);
   localparam logic [SAMPLE_DIV_W-1:0] SAMPLE_FALL_AT = SAMPLE_DIV_W'(SAMPLE_DIVIDE - 1);

   typedef struct packed {
      logic [1:0] clock_select_field;
      logic [3:0] internal_freq_select;
      logic fail_irq_enable;
      logic fail_flag;
      logic fail_cond;
      logic fail_clear_pending;
      logic [STARTUP_CNT_W-1:0] startup_count;
      logic startup_done;
      logic startup_status;
      clk_src_t src;
      clk_src_t pend;
      sw_state_t sw_state;
      logic pri_prev;
      logic sec_prev;
      logic int_prev;
      logic lf_prev;
      logic [SAMPLE_DIV_W-1:0] sample_div;
      logic detect_latch;
      logic half_armed;
      logic clk_out;
      logic irq;
      logic [7:0] rdata;
   } state_t;

   localparam state_t STATE_RESET = '{
      clock_select_field: SELECT_RESET,
      internal_freq_select: FREQ_RESET,
      src: SRC_NONE,
      pend: SRC_NONE,
      sw_state: SW_RUN,
      default: '0
   };

   state_t state_reg;
   state_t state_next;

   logic pri_fall;
   logic sec_fall;
   logic lf_rise;
   logic crystal_mode;
   logic internal_mode;
   logic sel_cfg;
   logic sel_sec;
   logic sel_int;
   logic needs_startup;
   logic startup_ok;
   logic two_speed;
   logic count_fall;
   logic sample_rise;
   logic sample_fall;
   logic monitor_armed;
   logic select_change;
   logic old_fall;
   logic new_fall;
   logic sec_ready;
   clk_src_t desired;

   // Level of the clock that a source would put on the system clock
   function automatic logic src_level(input clk_src_t src, input logic p, input logic s,
                                      input logic i);
      logic lvl;
      lvl = 1'b0;
      unique case (src)
         SRC_NONE: lvl = 1'b0;
         SRC_INT: lvl = i;
         SRC_PRI: lvl = p;
         SRC_SEC: lvl = s;
      endcase
      return lvl;
   endfunction : src_level

   // Edge detection on the oscillator samples, inputs are already synchronous
   assign pri_fall = state_reg.pri_prev & ~primary_osc_in;
   assign sec_fall = state_reg.sec_prev & ~secondary_osc_in;
   assign lf_rise = ~state_reg.lf_prev & low_freq_osc_in;

   // Mode decode from the configuration word and the select field
   assign crystal_mode = (config_oscillator_field == CFG_LOW_POWER_XTAL) |
                         (config_oscillator_field == CFG_STANDARD_XTAL) |
                         (config_oscillator_field == CFG_HIGH_SPEED_XTAL);
   assign internal_mode = config_oscillator_field == CFG_INTERNAL;
   assign sel_cfg = state_reg.clock_select_field == 2'h0;
   assign sel_sec = state_reg.clock_select_field == 2'h1;
   assign sel_int = state_reg.clock_select_field[1];
   assign needs_startup = sel_sec | (sel_cfg & crystal_mode);
   assign startup_ok = ~needs_startup | state_reg.startup_done;
   assign two_speed = switchover_config_bit & sel_cfg & crystal_mode;
   assign count_fall = sel_sec ? sec_fall : pri_fall;
   assign sec_ready = ~secondary_enable_bit | secondary_osc_ready_in;
   assign select_change = reg_wr & (reg_addr == CTRL_OFFSET) &
                          (reg_wdata[SELECT_LSB +: 2] != state_reg.clock_select_field);

   // Sample clock is the top divider bit of the low-frequency oscillator
   assign sample_rise = lf_rise & (state_reg.sample_div == SAMPLE_RISE_AT);
   assign sample_fall = lf_rise & (state_reg.sample_div == SAMPLE_FALL_AT);

   // The monitor only watches an external source once its count has expired
   assign monitor_armed = monitor_enable_config_bit & ~state_reg.fail_cond & startup_ok &
                          ((state_reg.src == SRC_PRI) | (state_reg.src == SRC_SEC)) &
                          (state_reg.sw_state == SW_RUN) & ~sleep_mode & power_up_done;

   // Source the block wants; failure outranks the select field without touching it
   assign desired = (sleep_mode | ~power_up_done) ? SRC_NONE :
                    (state_reg.fail_cond | sel_int) ? SRC_INT :
                    sel_sec ? (state_reg.startup_done ? SRC_SEC : state_reg.src) :
                    internal_mode ? SRC_INT :
                    ~crystal_mode ? SRC_PRI :
                    state_reg.startup_done ? SRC_PRI :
                    two_speed ? SRC_INT : SRC_NONE;

   // A stopped or failed outgoing clock cannot be waited on
   assign old_fall = (state_reg.src == SRC_NONE) | state_reg.fail_cond |
                     (src_level(state_reg.src, state_reg.pri_prev, state_reg.sec_prev,
                                state_reg.int_prev) &
                      ~src_level(state_reg.src, primary_osc_in, secondary_osc_in,
                                 internal_osc_in));
   assign new_fall = (desired == SRC_NONE) |
                     (src_level(desired, state_reg.pri_prev, state_reg.sec_prev,
                                state_reg.int_prev) &
                      ~src_level(desired, primary_osc_in, secondary_osc_in, internal_osc_in));

   // Next-state logic for the whole block
   always_comb
   begin
      state_next = state_reg;
      state_next.pri_prev = primary_osc_in;
      state_next.sec_prev = secondary_osc_in;
      state_next.int_prev = internal_osc_in;
      state_next.lf_prev = low_freq_osc_in;
      state_next.rdata = 8'h00;

      // Start-up counter: counts falling edges of the oscillator being brought up
      if (sleep_mode | ~power_up_done)
      begin
         state_next.startup_count = '0;
         state_next.startup_done = 1'b0;
      end
      else if (select_change)
      begin
         state_next.startup_count = '0;
         state_next.startup_done = 1'b0;
      end
      else if (needs_startup & ~state_reg.startup_done & count_fall)
      begin
         if (state_reg.startup_count == STARTUP_LAST)
         begin
            state_next.startup_done = 1'b1;
         end
         else
         begin
            state_next.startup_count = state_reg.startup_count + 1'b1;
         end
      end

      // Failure condition clearing: sleep at once, select change once the count expires
      if (sleep_mode)
      begin
         state_next.fail_cond = 1'b0;
         state_next.fail_clear_pending = 1'b0;
      end
      else if (select_change)
      begin
         state_next.fail_clear_pending = state_reg.fail_cond | state_reg.fail_clear_pending;
      end
      else if (state_reg.fail_clear_pending & startup_ok & power_up_done)
      begin
         state_next.fail_cond = 1'b0;
         state_next.fail_clear_pending = 1'b0;
      end

      // Sample divider runs free on the low-frequency oscillator
      if (lf_rise)
      begin
         state_next.sample_div = state_reg.sample_div + 1'b1;
      end

      // Register writes; the flag write comes first so a hardware set still wins
      if (reg_wr)
      begin
         unique case (reg_addr)
            CTRL_OFFSET:
            begin
               state_next.clock_select_field = reg_wdata[SELECT_LSB +: 2];
               state_next.internal_freq_select = reg_wdata[FREQ_LSB +: 4];
            end
            STAT_OFFSET:
            begin
               state_next.rdata = 8'h00; // Status is read-only
            end
            FLAG_OFFSET:
            begin
               if (reg_wdata[FAIL_FLAG_POS])
               begin
                  state_next.fail_flag = 1'b1;
               end
               else if (~state_reg.fail_cond)
               begin
                  state_next.fail_flag = 1'b0;
               end
            end
            IEN_OFFSET:
            begin
               state_next.fail_irq_enable = reg_wdata[FAIL_IEN_POS];
            end
         endcase
      end

      // Detector latch and half-cycle check against the sample clock
      if (sample_rise)
      begin
         state_next.detect_latch = count_fall;
         state_next.half_armed = monitor_armed;
      end
      else if (count_fall)
      begin
         state_next.detect_latch = 1'b1;
      end
      if (~monitor_armed)
      begin
         state_next.half_armed = 1'b0;
      end
      else if (sample_fall & state_reg.half_armed & ~state_reg.detect_latch & ~count_fall)
      begin
         state_next.fail_cond = 1'b1;
         state_next.fail_flag = 1'b1;
         state_next.half_armed = 1'b0;
      end

      // Glitch-free switch: wait for the old clock to fall, hold low, join new on its fall
      unique case (state_reg.sw_state)
         SW_RUN:
         begin
            if (desired != state_reg.src)
            begin
               state_next.pend = desired;
               state_next.sw_state = SW_HOLD;
            end
         end
         SW_HOLD:
         begin
            if (old_fall)
            begin
               state_next.startup_status = (state_reg.pend == SRC_PRI);
               state_next.sw_state = SW_WAIT_NEW;
            end
         end
         SW_WAIT_NEW:
         begin
            // The target follows the wanted source so a late failure is not missed
            state_next.pend = desired;
            if (new_fall)
            begin
               state_next.src = desired;
               state_next.startup_status = (desired == SRC_PRI);
               state_next.sw_state = SW_RUN;
            end
         end
         default:
         begin
            state_next.sw_state = SW_RUN;
         end
      endcase
      if (sleep_mode)
      begin
         state_next.startup_status = 1'b0;
      end

      // Clock output follows the running source, held low while joining the new one
      if (state_reg.sw_state == SW_WAIT_NEW)
      begin
         state_next.clk_out = 1'b0;
      end
      else
      begin
         state_next.clk_out = src_level(state_reg.src, primary_osc_in, secondary_osc_in,
                                        internal_osc_in);
      end

      // Interrupt request: flag gated by its enable
      state_next.irq = state_next.fail_flag & state_next.fail_irq_enable;

      // Read data stands in the cycle after the read strobe only
      if (reg_rd)
      begin
         unique case (reg_addr)
            CTRL_OFFSET:
            begin
               state_next.rdata[SELECT_LSB +: 2] = state_reg.clock_select_field;
               state_next.rdata[FREQ_LSB +: 4] = state_reg.internal_freq_select;
            end
            STAT_OFFSET:
            begin
               state_next.rdata[SEC_READY_POS] = sec_ready;
               state_next.rdata[STARTUP_STATUS_POS] = state_reg.startup_status;
            end
            FLAG_OFFSET:
            begin
               state_next.rdata[FAIL_FLAG_POS] = state_reg.fail_flag;
            end
            IEN_OFFSET:
            begin
               state_next.rdata[FAIL_IEN_POS] = state_reg.fail_irq_enable;
            end
         endcase
      end
   end

   // Single state register; reset puts the select field back to the configured source
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= STATE_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata = state_reg.rdata;
   assign system_clk_out = state_reg.clk_out;
   assign internal_freq_select = state_reg.internal_freq_select;
   assign active_source = state_reg.src;
   assign osc_fail_irq = state_reg.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   // Joining the secondary needs select 01 and no failure in the cycle before;
   // a later select write may legally leave it running until the old clock falls and the switch away completes
   sec_source_a: assert property (
      (state_reg.src == SRC_SEC && $past(state_reg.src) != SRC_SEC)
      |-> ($past(state_reg.clock_select_field) == 2'h1 && !$past(state_reg.fail_cond)))
      else $error("secondary source without select 01");

   // Joining the configured source needs select 00 and a non-internal mode
   cfg_source_a: assert property (
      (state_reg.src == SRC_PRI && $past(state_reg.src) != SRC_PRI)
      |-> ($past(state_reg.clock_select_field) == 2'h0
           && $past(config_oscillator_field) != CFG_INTERNAL))
      else $error("configured source used with wrong select");

   // Select field changes only through a control write
   select_stable_a: assert property (
      !(reg_wr && reg_addr == CTRL_OFFSET) |=> $stable(state_reg.clock_select_field))
      else $error("select field changed without a write");

   // Start-up status clear whenever the internal clock runs
   status_internal_a: assert property (
      (state_reg.sw_state == SW_RUN && state_reg.src == SRC_INT) |-> !state_reg.startup_status)
      else $error("start-up status set on internal clock");

   // Sleep aborts the count and clears status
   sleep_abort_a: assert property (
      sleep_mode |=> (!state_reg.startup_done && state_reg.startup_count == '0
                      && !state_reg.startup_status))
      else $error("sleep did not abort start-up");

   // Count expires only at the last oscillator edge
   count_expire_a: assert property (
      $rose(state_reg.startup_done) |-> (state_reg.startup_count == STARTUP_LAST
                                         && $past(count_fall)))
      else $error("start-up count expired early");

   // No failure before the count has expired
   fail_after_count_a: assert property (
      $rose(state_reg.fail_cond) |-> ($past(startup_ok) && $past(monitor_enable_config_bit)))
      else $error("failure declared before start-up expired");

   // A failure raises the flag together
   fail_flag_set_a: assert property (
      $rose(state_reg.fail_cond) |-> state_reg.fail_flag)
      else $error("failure without fail flag");

   // Flag cannot be cleared while the failure stands
   flag_hold_a: assert property (
      (reg_wr && reg_addr == FLAG_OFFSET && !reg_wdata[FAIL_FLAG_POS] && state_reg.fail_cond)
      |=> state_reg.fail_flag)
      else $error("fail flag cleared during failure");

   // While joining a new source the system clock stays low
   hold_low_a: assert property (
      (state_reg.sw_state == SW_WAIT_NEW) |=> !system_clk_out)
      else $error("system clock high during switch");

   // Disabled secondary reads ready
   ready_disabled_a: assert property (
      (reg_rd && reg_addr == STAT_OFFSET && !secondary_enable_bit) |=> reg_rdata[SEC_READY_POS])
      else $error("ready bit low with secondary disabled");

   // After a failure the external source is not resumed while it stands
   stay_internal_a: assert property (
      (state_reg.fail_cond && $past(state_reg.fail_cond) && state_reg.sw_state == SW_RUN)
      |-> (state_reg.src == SRC_INT || state_reg.src == SRC_NONE))
      else $error("external source resumed during failure");

endmodule : system_clock_switch_failsafe

// File: osc_sources_model.sv
// Behavioural oscillator sources feeding the system clock switch
`timescale 1ns/1ps
module osc_sources_model
(
   input wire logic sys_clk,
   input wire logic primary_run,
   output logic primary_osc,
   output logic secondary_osc,
   output logic internal_osc,
   output logic low_freq_osc
);
   logic [5:0] tick_reg = 6'h00;

   // Shared phase counter; every source is slower than sys_clk so no edge is lost
   always @(posedge sys_clk)
   begin
      tick_reg <= (tick_reg == 6'h3b) ? 6'h00 : tick_reg + 6'h01;
   end

   // A stopped crystal parks high, so the monitor sees no falling edge at all
   assign primary_osc = primary_run ? ((tick_reg % 6) < 3) : 1'b1;
   assign secondary_osc = (tick_reg % 10) < 5; // Period of ten cycles
   assign internal_osc = tick_reg[1];
   assign low_freq_osc = tick_reg[0]; // Sample clock is then 128 cycles long
endmodule : osc_sources_model

// File: system_clock_switch_failsafe_tb_top.sv
// Self-checking bench for the system clock switch and fail-safe monitor
`timescale 1ns/1ps
module system_clock_switch_failsafe_tb_top
   import clock_switch_pkg::*;
;
   localparam int SIM_STARTUP = 8;
   logic sys_clk, resetn, reg_wr, reg_rd, primary_run, sec_en, sec_rdy, sleep_mode;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic system_clk_out, osc_fail_irq, pri, sec, intl, lfo;
   logic [3:0] internal_freq_select;
   logic [1:0] active_source;
   int bad_count, total_checks, cycle_count;

   osc_sources_model osc (.sys_clk(sys_clk), .primary_run(primary_run), .primary_osc(pri),
      .secondary_osc(sec), .internal_osc(intl), .low_freq_osc(lfo));

   system_clock_switch_failsafe #(.STARTUP_CYCLES(SIM_STARTUP)) dut (.sys_clk(sys_clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_oscillator_field(CFG_LOW_POWER_XTAL),
      .switchover_config_bit(1'b1), .monitor_enable_config_bit(1'b1), .power_up_done(1'b1),
      .sleep_mode(sleep_mode), .primary_osc_in(pri), .secondary_osc_in(sec),
      .internal_osc_in(intl),
      .low_freq_osc_in(lfo), .secondary_enable_bit(sec_en), .secondary_osc_ready_in(sec_rdy),
      .system_clk_out(system_clk_out), .internal_freq_select(internal_freq_select),
      .active_source(active_source), .osc_fail_irq(osc_fail_irq));

   // Free-running 20 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8

   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      check8(rd_val, exp);
   endtask : reg_read

   // Bounded wait for a source change; a hang shows as a mismatch
   task automatic wait_src(input logic [1:0] s, input int limit);
      int n;
      n = 0;
      while (active_source !== s && n < limit)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      check8({6'h00, active_source}, {6'h00, s});
   endtask : wait_src

   // System clock must copy the running source level one cycle late
   task automatic check_follow;
      logic lvl;
      @(posedge sys_clk);
      #1 lvl = sec;
      @(posedge sys_clk);
      #1 check8({7'h00, system_clk_out}, {7'h00, lvl});
   endtask : check_follow

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // Ceiling well above the thousand or so cycles the tests need
   always @(posedge sys_clk)
   begin
      cycle_count++;
      if (cycle_count == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end

   initial
   begin
      {resetn, reg_wr, reg_rd, sec_en, sec_rdy, sleep_mode, reg_addr, reg_wdata} = '0;
      primary_run = 1'b1;
      bad_count = 0;
      total_checks = 0;
      cycle_count = 0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      reg_read(CTRL_OFFSET, 8'h38);
      reg_read(STAT_OFFSET, 8'h80);
      reg_read(FLAG_OFFSET, 8'h00);
      reg_read(IEN_OFFSET, 8'h00);
      $display("reset values test done");
      wait_src(SRC_INT, 20);
      repeat (12) @(posedge sys_clk);
      #1 check8({6'h00, active_source}, {6'h00, SRC_INT});
      wait_src(SRC_PRI, 200);
      reg_read(STAT_OFFSET, 8'ha0);
      $display("two-speed start-up test done");
      reg_write(IEN_OFFSET, 8'h80);
      primary_run <= 1'b0;
      wait_src(SRC_INT, 600);
      check8({7'h00, osc_fail_irq}, 8'h01);
      reg_read(CTRL_OFFSET, 8'h38);
      reg_write(FLAG_OFFSET, 8'h00);
      reg_read(FLAG_OFFSET, 8'h80);
      repeat (300) @(posedge sys_clk);
      #1 check8({6'h00, active_source}, {6'h00, SRC_INT});
      reg_read(STAT_OFFSET, 8'h80);
      $display("fail-safe test done");
      // Stimulus moves only on a rising edge, never at the sampling offset
      @(posedge sys_clk);
      primary_run <= 1'b1;
      reg_write(CTRL_OFFSET, 8'h52);
      wait_src(SRC_INT, 20);
      reg_write(FLAG_OFFSET, 8'h00);
      reg_read(FLAG_OFFSET, 8'h00);
      check8({7'h00, osc_fail_irq}, 8'h00);
      check8({4'h0, internal_freq_select}, 8'h0a);
      $display("fail clearing test done");
      @(posedge sys_clk);
      sec_en <= 1'b1;
      reg_read(STAT_OFFSET, 8'h00);
      @(posedge sys_clk);
      sec_rdy <= 1'b1;
      reg_read(STAT_OFFSET, 8'h80);
      reg_write(CTRL_OFFSET, 8'h39);
      wait_src(SRC_SEC, 300);
      reg_read(STAT_OFFSET, 8'h80);
      check8({6'h00, active_source}, {6'h00, SRC_SEC});
      repeat (10) check_follow();
      $display("secondary oscillator test done");
      // Sleep must discard the finished count, so waking waits a full count again
      @(posedge sys_clk);
      sleep_mode <= 1'b1;
      wait_src(SRC_NONE, 30);
      reg_read(STAT_OFFSET, 8'h80);
      @(posedge sys_clk);
      sleep_mode <= 1'b0;
      repeat (40) @(posedge sys_clk);
      #1 check8({6'h00, active_source}, {6'h00, SRC_NONE});
      wait_src(SRC_SEC, 300);
      $display("sleep test done");
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      reg_read(CTRL_OFFSET, 8'h38);
      $display("second reset test done");
      stop_test();
   end
endmodule : system_clock_switch_failsafe_tb_top
